// ==== rtl/tmc_pkg.sv ====
// Constants, types and states of the trim menu controller.
// Assumes a 100 MHz clock and a classic Wishbone register bus.
package tmc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEB_MS = 10;
  localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
  localparam int unsigned CHORD_MS = 30;
  localparam int unsigned CHORD_CYC = CLK_HZ / 1000 * CHORD_MS;
  localparam int unsigned TMO_S = 10;
  localparam int unsigned TMO_CYC = CLK_HZ * TMO_S;
  localparam int unsigned ENT_MS = 500;
  localparam int unsigned ENT_CYC = CLK_HZ / 1000 * ENT_MS;
  localparam int unsigned DPW_MS = 2000;
  localparam int unsigned DPW_CYC = CLK_HZ / 1000 * DPW_MS;
  // ----------------------------------------------------------------
  // Register offsets and values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CODE = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_TRIMZ = 8'h0C;
  localparam logic [7:0] ADR_TRIMS = 8'h10;
  localparam logic [7:0] ADR_REF = 8'h14;
  localparam int CTRL_REF_BIT = 0;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] REF4_NOM = 16'h0FA0;
  localparam logic [15:0] REF20_NOM = 16'h4E20;
  localparam logic [15:0] REF_RST = 16'h0000;
  localparam logic [1:0] SENS_TC = 2'h0;
  localparam logic [1:0] SENS_LAST = 2'h2;
  localparam logic [2:0] TC_LAST = 3'h6;
  localparam logic [1:0] NV_ZERO = 2'h0;
  localparam logic [1:0] NV_SPAN = 2'h1;
  localparam logic [1:0] NV_REF = 2'h2;
  localparam logic [1:0] NV_CLEAR = 2'h3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic p;
    logic e;
    logic up;
    logic dn;
  } tmc_btn_t;
  typedef struct packed {
    logic [15:0] dofs;
    logic [15:0] cofs;
  } tmc_trim_t;
  localparam tmc_trim_t TRIM_RST = 32'h0000_0000;
  typedef enum logic [4:0] {
    ST_DISP = 5'b00000, ST_CODE_P = 5'b00001, ST_CODE_E = 5'b00010,
    ST_DPW = 5'b00011, ST_INPUT = 5'b00100, ST_SENSOR = 5'b00101,
    ST_TC_TYPE = 5'b00110, ST_TC_CH = 5'b00111, ST_ZERO = 5'b01000,
    ST_SPAN = 5'b01001, ST_CLR = 5'b01010, ST_SHOW = 5'b01011,
    ST_CORR = 5'b01100, ST_ENT = 5'b01101, ST_CUR = 5'b01110,
    ST_REF_ITEM = 5'b01111, ST_REF_SURE = 5'b10000,
    ST_REF_ZERO = 5'b10001, ST_REF_SPAN = 5'b10010,
    ST_REF_ADJ4 = 5'b10011, ST_REF_ADJ20 = 5'b10100
  } tmc_state_t;
endpackage : tmc_pkg

// ==== rtl/tmc_trim_menu.sv ====
// Front-panel menu controller: buttons, security code, trim menu,
// output reference calibration and first programme menu steps.
// Assumes buttons arrive asynchronously, active high when pressed.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
module tmc_trim_menu
  import tmc_pkg::*;
#(
  parameter int unsigned P_DEB_CYC = DEB_CYC,
  parameter int unsigned P_CHORD_CYC = CHORD_CYC,
  parameter int unsigned P_TMO_CYC = TMO_CYC,
  parameter int unsigned P_ENT_CYC = ENT_CYC,
  parameter int unsigned P_DPW_CYC = DPW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire tmc_btn_t btn_i,
  input wire logic [15:0] meas_i,
  input wire logic [15:0] out_nom_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output tmc_state_t disp_state_o,
  output logic [15:0] disp_val_o,
  output logic [1:0] flash_digit_o,
  output logic annun_o,
  output logic hold_o,
  output logic dp_all_o,
  output logic [15:0] out_set_o,
  output logic nv_we_o,
  output logic [1:0] nv_addr_o,
  output logic [31:0] nv_data_o
);
  // ----------------------------------------------------------------
  // Button synchroniser and debounce
  // ----------------------------------------------------------------
  logic [3:0] btn_s1_q;
  logic [3:0] btn_s2_q;
  logic [3:0] deb_q;
  logic [3:0] deb_d1_q;
  logic [3:0] rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_s1_q <= 4'h0;
      btn_s2_q <= 4'h0;
      deb_d1_q <= 4'h0;
    end else if (ce_i) begin
      btn_s1_q <= btn_i;
      btn_s2_q <= btn_s1_q;
      deb_d1_q <= deb_q;
    end
  end

  for (genvar gi = 0; gi < 4; gi++) begin : g_deb
    logic [21:0] cnt_q;
    logic bit_q;
    assign deb_q[gi] = bit_q;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_q <= '0;
        bit_q <= 1'b0;
      end else if (ce_i) begin
        if (btn_s2_q[gi] == bit_q) begin
          cnt_q <= '0;
        end else if (cnt_q >= 22'(P_DEB_CYC - 1)) begin
          cnt_q <= '0;
          bit_q <= btn_s2_q[gi];
        end else begin
          cnt_q <= cnt_q + 22'h1;
        end
      end
    end
  end

  assign rise = deb_q & ~deb_d1_q;

  // ----------------------------------------------------------------
  // Chord window and key events
  // ----------------------------------------------------------------
  logic win_q;
  logic [21:0] wcnt_q;
  tmc_btn_t acc_q;
  tmc_btn_t kev_q;
  logic ch_trim_q;
  logic ch_prog_q;
  tmc_btn_t held_b;

  assign held_b = deb_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q <= 1'b0;
      wcnt_q <= '0;
      acc_q <= 4'h0;
      kev_q <= 4'h0;
      ch_trim_q <= 1'b0;
      ch_prog_q <= 1'b0;
    end else if (ce_i) begin
      kev_q <= 4'h0;
      ch_trim_q <= 1'b0;
      ch_prog_q <= 1'b0;
      if (!win_q) begin
        if (|rise) begin
          win_q <= 1'b1;
          wcnt_q <= '0;
          acc_q <= rise;
        end
      end else if (wcnt_q >= 22'(P_CHORD_CYC - 1)) begin
        win_q <= 1'b0;
        if (acc_q.p && acc_q.dn && held_b.p && held_b.dn) begin
          ch_trim_q <= 1'b1;
        end else if (acc_q.p && acc_q.e && held_b.p && held_b.e) begin
          ch_prog_q <= 1'b1;
        end else begin
          kev_q <= acc_q | rise;
        end
      end else begin
        wcnt_q <= wcnt_q + 22'h1;
        acc_q <= acc_q | rise;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [15:0] code_q;
  logic ref_cmd_q;
  tmc_state_t st_q;
  tmc_trim_t trim_q [2];
  logic [15:0] ref_q [2];
  logic wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      code_q <= CODE_RST;
      ref_cmd_q <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      ref_cmd_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == ADR_CTRL) begin
          ref_cmd_q <= wb_sel_i[0] && wb_dat_i[CTRL_REF_BIT];
        end else if (wb_adr_i == ADR_CODE) begin
          if (wb_sel_i[0]) code_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) code_q[15:8] <= wb_dat_i[15:8];
        end
      end else if (wb_req) begin
        if (wb_adr_i == ADR_CODE) begin
          wb_dat_o <= {16'h0000, code_q};
        end else if (wb_adr_i == ADR_STAT) begin
          wb_dat_o <= {24'h000000, annun_o, hold_o, dp_all_o, st_q};
        end else if (wb_adr_i == ADR_TRIMZ) begin
          wb_dat_o <= trim_q[0];
        end else if (wb_adr_i == ADR_TRIMS) begin
          wb_dat_o <= trim_q[1];
        end else if (wb_adr_i == ADR_REF) begin
          wb_dat_o <= {ref_q[1], ref_q[0]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State timer
  // ----------------------------------------------------------------
  logic [29:0] tmr_q;
  tmc_state_t st_last_q;
  logic tmo;
  logic ent_done;
  logic dpw_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_q <= '0;
      st_last_q <= ST_DISP;
    end else if (ce_i) begin
      st_last_q <= st_q;
      if (st_q != st_last_q || |kev_q || ch_trim_q || ch_prog_q) begin
        tmr_q <= '0;
      end else if (tmr_q != '1) begin
        tmr_q <= tmr_q + 30'h1;
      end
    end
  end

  assign tmo = tmr_q >= 30'(P_TMO_CYC - 1);
  assign ent_done = tmr_q >= 30'(P_ENT_CYC - 1);
  assign dpw_done = tmr_q >= 30'(P_DPW_CYC - 1);

  // ----------------------------------------------------------------
  // Menu state machine
  // ----------------------------------------------------------------
  function automatic logic [3:0] dig_step(input logic [3:0] d,
                                          input logic up);
    if (up) begin
      dig_step = (d == 4'h9) ? 4'h0 : d + 4'h1;
    end else begin
      dig_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
    end
  endfunction : dig_step

  tmc_state_t ent_ret_q;
  tmc_state_t prompt;
  logic prog_q;
  logic sel_q;
  logic [15:0] dig_q;
  logic [1:0] didx_q;
  logic [15:0] held_q;
  tmc_trim_t work_q;
  logic [1:0] sensor_q;
  logic [2:0] tc_q;
  logic nv_q;
  logic [1:0] nv_addr_q;
  logic ud;
  logic [15:0] step;
  logic [3:0] dig_cur;

  assign ud = kev_q.up || kev_q.dn;
  assign step = kev_q.up ? 16'h0001 : 16'hFFFF;
  assign prompt = sel_q ? ST_SPAN : ST_ZERO;
  assign dig_cur = dig_q[{didx_q, 2'b00} +: 4];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_DISP;
      ent_ret_q <= ST_DISP;
      prog_q <= 1'b0;
      sel_q <= 1'b0;
      dig_q <= 16'h0000;
      didx_q <= 2'h0;
      held_q <= 16'h0000;
      work_q <= TRIM_RST;
      trim_q[0] <= TRIM_RST;
      trim_q[1] <= TRIM_RST;
      ref_q[0] <= REF_RST;
      ref_q[1] <= REF_RST;
      sensor_q <= SENS_TC;
      tc_q <= 3'h0;
      nv_q <= 1'b0;
      nv_addr_q <= NV_ZERO;
    end else if (ce_i) begin
      nv_q <= 1'b0;
      case (st_q)
        ST_DISP: begin
          if (ch_trim_q) begin
            prog_q <= 1'b0;
            st_q <= (code_q == CODE_NONE) ? ST_ZERO : ST_CODE_P;
          end else if (ch_prog_q) begin
            prog_q <= 1'b1;
            st_q <= (code_q == CODE_NONE) ? ST_DPW : ST_CODE_P;
          end else if (ref_cmd_q) begin
            st_q <= ST_REF_ITEM;
          end
        end
        ST_CODE_P: begin
          if (tmo || kev_q.e) begin
            st_q <= ST_DISP;
          end else if (kev_q.p) begin
            st_q <= ST_CODE_E;
            dig_q <= 16'h0000;
            didx_q <= 2'h3;
          end
        end
        ST_CODE_E: begin
          if (tmo) begin
            st_q <= ST_DISP;
          end else if (kev_q.e) begin
            if (dig_q != code_q) begin
              st_q <= ST_DISP;
            end else begin
              st_q <= prog_q ? ST_DPW : ST_ZERO;
            end
          end else if (kev_q.p) begin
            didx_q <= didx_q - 2'h1;
          end else if (ud) begin
            dig_q[{didx_q, 2'b00} +: 4] <= dig_step(dig_cur, kev_q.up);
          end
        end
        ST_DPW: if (dpw_done) st_q <= ST_INPUT;
        ST_INPUT: begin
          if (kev_q.p) st_q <= ST_SENSOR;
          else if (kev_q.e) st_q <= ST_DISP;
        end
        ST_SENSOR: begin
          if (kev_q.p && sensor_q == SENS_TC) begin
            st_q <= ST_TC_TYPE;
          end else if (kev_q.e) begin
            st_q <= ST_INPUT;
          end else if (kev_q.up) begin
            sensor_q <= (sensor_q == SENS_LAST) ? 2'h0 : sensor_q + 2'h1;
          end else if (kev_q.dn) begin
            sensor_q <= (sensor_q == 2'h0) ? SENS_LAST : sensor_q - 2'h1;
          end
        end
        ST_TC_TYPE: begin
          if (kev_q.p) st_q <= ST_TC_CH;
          else if (kev_q.e) st_q <= ST_SENSOR;
        end
        ST_TC_CH: begin
          if (kev_q.e) begin
            st_q <= ST_TC_TYPE;
          end else if (kev_q.up) begin
            tc_q <= (tc_q == TC_LAST) ? 3'h0 : tc_q + 3'h1;
          end else if (kev_q.dn) begin
            tc_q <= (tc_q == 3'h0) ? TC_LAST : tc_q - 3'h1;
          end
        end
        ST_ZERO, ST_SPAN: begin
          if (kev_q.p) begin
            st_q <= ST_SHOW;
            sel_q <= (st_q == ST_SPAN);
            work_q <= trim_q[st_q == ST_SPAN];
          end else if (kev_q.e) begin
            st_q <= ST_DISP;
          end else if (kev_q.up) begin
            st_q <= (st_q == ST_ZERO) ? ST_SPAN : ST_CLR;
          end else if (kev_q.dn) begin
            st_q <= (st_q == ST_ZERO) ? ST_CLR : ST_ZERO;
          end
        end
        ST_CLR: begin
          if (kev_q.p) begin
            trim_q[0] <= TRIM_RST;
            trim_q[1] <= TRIM_RST;
            nv_q <= 1'b1;
            nv_addr_q <= NV_CLEAR;
            ent_ret_q <= ST_CLR;
            st_q <= ST_ENT;
          end else if (kev_q.e) begin
            st_q <= ST_DISP;
          end else if (kev_q.up) begin
            st_q <= ST_ZERO;
          end else if (kev_q.dn) begin
            st_q <= ST_SPAN;
          end
        end
        ST_SHOW, ST_CORR: begin
          if (kev_q.p) begin
            if (st_q == ST_SHOW) held_q <= meas_i;
            ent_ret_q <= ST_CUR;
            st_q <= ST_ENT;
          end else if (kev_q.e) begin
            st_q <= prompt;
          end else if (ud) begin
            held_q <= ((st_q == ST_SHOW) ? meas_i : held_q) + step;
            work_q.dofs <= work_q.dofs + step;
            st_q <= ST_CORR;
          end
        end
        ST_ENT: if (ent_done) st_q <= ent_ret_q;
        ST_CUR: begin
          if (kev_q.e) begin
            trim_q[sel_q] <= work_q;
            nv_q <= 1'b1;
            nv_addr_q <= sel_q ? NV_SPAN : NV_ZERO;
            st_q <= prompt;
          end else if (ud) begin
            work_q.cofs <= work_q.cofs + step;
          end
        end
        ST_REF_ITEM: begin
          if (kev_q.p) st_q <= ST_REF_SURE;
          else if (kev_q.e) st_q <= ST_DISP;
        end
        ST_REF_SURE: begin
          if (kev_q.p) st_q <= ST_REF_ZERO;
          else if (kev_q.e) st_q <= ST_REF_ITEM;
        end
        ST_REF_ZERO, ST_REF_SPAN: begin
          if (kev_q.p) begin
            st_q <= (st_q == ST_REF_ZERO) ? ST_REF_ADJ4 : ST_REF_ADJ20;
          end else if (kev_q.e) begin
            st_q <= ST_REF_ITEM;
          end else if (ud) begin
            st_q <= (st_q == ST_REF_ZERO) ? ST_REF_SPAN : ST_REF_ZERO;
          end
        end
        ST_REF_ADJ4, ST_REF_ADJ20: begin
          if (kev_q.e) begin
            nv_q <= 1'b1;
            nv_addr_q <= NV_REF;
            st_q <= (st_q == ST_REF_ADJ4) ? ST_REF_ZERO : ST_REF_SPAN;
          end else if (ud) begin
            ref_q[st_q == ST_REF_ADJ20] <=
              ref_q[st_q == ST_REF_ADJ20] + step;
          end
        end
        default: st_q <= ST_DISP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_state_o <= ST_DISP;
      disp_val_o <= 16'h0000;
      flash_digit_o <= 2'h0;
      annun_o <= 1'b0;
      hold_o <= 1'b0;
      dp_all_o <= 1'b0;
      out_set_o <= 16'h0000;
      nv_we_o <= 1'b0;
      nv_addr_o <= NV_ZERO;
      nv_data_o <= 32'h0000_0000;
    end else if (ce_i) begin
      disp_state_o <= st_q;
      flash_digit_o <= didx_q;
      annun_o <= (st_q == ST_CORR);
      hold_o <= (st_q == ST_CORR || st_q == ST_ENT || st_q == ST_CUR);
      dp_all_o <= (st_q == ST_DPW);
      nv_we_o <= nv_q;
      nv_addr_o <= nv_addr_q;
      if (nv_addr_q == NV_REF) begin
        nv_data_o <= {ref_q[1], ref_q[0]};
      end else if (nv_addr_q == NV_CLEAR) begin
        nv_data_o <= 32'h0000_0000;
      end else begin
        nv_data_o <= trim_q[nv_addr_q[0]];
      end
      case (st_q)
        ST_CODE_E: disp_val_o <= dig_q;
        ST_SHOW: disp_val_o <= meas_i;
        ST_CORR, ST_ENT, ST_CUR: disp_val_o <= held_q;
        ST_SENSOR: disp_val_o <= {14'h0000, sensor_q};
        ST_TC_CH: disp_val_o <= {13'h0000, tc_q};
        ST_REF_ADJ4: disp_val_o <= REF4_NOM;
        ST_REF_ADJ20: disp_val_o <= REF20_NOM;
        default: disp_val_o <= meas_i;
      endcase
      case (st_q)
        ST_REF_ADJ4: out_set_o <= REF4_NOM + ref_q[0];
        ST_REF_ADJ20: out_set_o <= REF20_NOM + ref_q[1];
        ST_CUR: out_set_o <= out_nom_i + work_q.cofs;
        default: out_set_o <= out_nom_i;
      endcase
    end
  end
endmodule : tmc_trim_menu

// ==== test/tmc_operator.sv ====
// Operator model: one person on the four panel push-buttons.
// Assumes the menu clock; presses one button pattern at a time.
module tmc_operator
  import tmc_pkg::*;
(
  input wire logic clk_i,
  output tmc_btn_t btn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial btn_o = 4'h0;
  // ----------------------------------------------------------------
  // Press past debounce and chord window, then release
  // ----------------------------------------------------------------
  task automatic push(input tmc_btn_t b);
    @(posedge clk_i);
    btn_o <= b;
    repeat (30) @(posedge clk_i);
    btn_o <= 4'h0;
    repeat (30) @(posedge clk_i);
  endtask : push
endmodule : tmc_operator

// ==== test/tmc_menu_props.sv ====
// Checker of the menu controller's panel-side outputs.
// Assumes shortened counts from the bench; bound to the top module.
module tmc_menu_props
  import tmc_pkg::*;
#(
  parameter int unsigned P_TMO_CYC = TMO_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tmc_btn_t btn_i,
  input wire tmc_state_t disp_state_o,
  input wire logic [15:0] disp_val_o,
  input wire logic annun_o,
  input wire logic hold_o,
  input wire logic dp_all_o,
  input wire logic [15:0] out_set_o,
  input wire logic nv_we_o,
  input wire logic [1:0] nv_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] idle_q;
  logic code_st;
  assign code_st = disp_state_o == ST_CODE_P || disp_state_o == ST_CODE_E;
  always_ff @(posedge clk_i) begin
    if (rst_i || !code_st || btn_i != 4'h0) begin
      idle_q <= 32'h0;
    end else begin
      idle_q <= idle_q + 32'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_corr_annun: assert property (
    (disp_state_o == ST_CORR) [*2] |-> annun_o && hold_o)
    else $error("annunciator or hold missing in correction");
  chk_ent_locked: assert property (
    (disp_state_o == ST_ENT) [*3] |-> $stable(disp_val_o) && hold_o)
    else $error("value not locked during acknowledge");
  chk_ent_brief: assert property (
    $rose(disp_state_o == ST_ENT) |->
      ##[1:40] (disp_state_o == ST_CUR || disp_state_o == ST_CLR))
    else $error("acknowledge prompt not left in time");
  chk_dpw_points: assert property (
    (disp_state_o == ST_DPW) [*2] |-> dp_all_o)
    else $error("decimal points not lit");
  chk_dpw_exit: assert property (
    $rose(disp_state_o == ST_DPW) |-> ##[1:60] disp_state_o == ST_INPUT)
    else $error("input parameter not reached after points");
  chk_ref4_near: assert property (
    (disp_state_o == ST_REF_ADJ4) [*2] |->
      out_set_o - REF4_NOM < 16'h0100)
    else $error("output not near 4 mA");
  chk_ref20_near: assert property (
    (disp_state_o == ST_REF_ADJ20) [*2] |->
      out_set_o - REF20_NOM < 16'h0100)
    else $error("output not near 20 mA");
  chk_store_zero: assert property (
    nv_we_o && nv_addr_o == NV_ZERO |-> ##[0:2] disp_state_o == ST_ZERO)
    else $error("zero store without return to zero prompt");
  chk_store_pulse: assert property (
    nv_we_o |=> !nv_we_o)
    else $error("store strobe longer than one cycle");
  chk_code_timeout: assert property (
    idle_q <= P_TMO_CYC + 40)
    else $error("code entry did not time out");
endmodule : tmc_menu_props

bind tmc_trim_menu tmc_menu_props #(.P_TMO_CYC(P_TMO_CYC)) u_props (
  .clk_i, .rst_i, .btn_i, .disp_state_o, .disp_val_o, .annun_o, .hold_o,
  .dp_all_o, .out_set_o, .nv_we_o, .nv_addr_o);

// ==== test/tmc_trim_menu_bench.sv ====
// Self-checking bench of the trim menu controller.
// Assumes the operator model on the buttons and Wishbone tasks here.
module tmc_trim_menu_bench
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam tmc_btn_t BP = 4'h8;
  localparam tmc_btn_t BE = 4'h4;
  localparam tmc_btn_t BU = 4'h2;
  localparam tmc_btn_t BD = 4'h1;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] meas = 16'h0123;
  logic [15:0] nom = 16'h2000;
  logic [31:0] rdat;
  logic ack, ann, hld, nvw;
  tmc_state_t st;
  tmc_btn_t btn;
  logic [15:0] dval, oset;
  logic [1:0] fdig, nva;
  logic [1:0] nv_seen = 2'h0;
  logic [31:0] nvd_seen = 32'h0;
  logic [31:0] nvd;
  logic dpa;
  logic dp_seen = 1'b0;
  logic ce = 1'b1;
  logic [3:0] bsel = 4'hF;
  logic [31:0] r;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (nvw === 1'b1) begin
      nv_seen <= nva;
      nvd_seen <= nvd;
    end
    if (dpa === 1'b1) dp_seen <= 1'b1;
  end
  tmc_operator op (.clk_i, .btn_o(btn));
  tmc_trim_menu #(.P_DEB_CYC(4), .P_CHORD_CYC(8), .P_TMO_CYC(200),
    .P_ENT_CYC(10), .P_DPW_CYC(20)) uut (
    .clk_i, .rst_i, .ce_i(ce), .btn_i(btn), .meas_i(meas),
    .out_nom_i(nom), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .disp_state_o(st), .disp_val_o(dval),
    .flash_digit_o(fdig), .annun_o(ann), .hold_o(hld), .dp_all_o(dpa),
    .out_set_o(oset), .nv_we_o(nvw), .nv_addr_o(nva), .nv_data_o(nvd));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic key(input tmc_btn_t b, input tmc_state_t s);
    op.push(b);
    chk(st, s);
  endtask : key
  task automatic digits(input logic [15:0] c);
    for (int i = 3; i >= 0; i--) begin
      repeat (c[i*4+:4]) op.push(BU);
      chk(dval[i*4+:4], c[i*4+:4]);
      op.push(BP);
    end
  endtask : digits
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_adj(input tmc_state_t pr, input logic [1:0] a);
    logic [15:0] v;
    key(BP, ST_SHOW);
    chk(dval, meas);
    chk(oset, nom);
    v = meas + 16'h0001;
    key(BU, ST_CORR);
    chk({ann, hld, dval}, {2'b11, v});
    @(posedge clk_i);
    meas <= meas + 16'h0100;
    repeat (4) @(posedge clk_i);
    chk(dval, v);
    key(BP, ST_CUR);
    key(BU, ST_CUR);
    chk(oset, nom + 16'h0001);
    key(BE, pr);
    chk(nv_seen, a);
    chk(nvd_seen, 32'h0001_0001);
    wb(1'b0, (a == NV_ZERO) ? ADR_TRIMZ : ADR_TRIMS, 32'h0, r);
    chk(r, 32'h0001_0001);
  endtask : t_adj
  task automatic t_trim_free();
    key(BP | BD, ST_ZERO);
    t_adj(ST_ZERO, NV_ZERO);
    key(BU, ST_SPAN);
    nom <= 16'h3000;
    t_adj(ST_SPAN, NV_SPAN);
    key(BU, ST_CLR);
    key(BP, ST_CLR);
    chk(nv_seen, NV_CLEAR);
    wb(1'b0, ADR_TRIMZ, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b0, ADR_TRIMS, 32'h0, r);
    chk(r, 32'h0);
  endtask : t_trim_free
  task automatic t_ref();
    wb(1'b1, ADR_CTRL, 32'h1, r);
    repeat (3) @(posedge clk_i);
    chk(st, ST_REF_ITEM);
    key(BP, ST_REF_SURE);
    key(BP, ST_REF_ZERO);
    key(BP, ST_REF_ADJ4);
    chk({dval, oset}, {REF4_NOM, REF4_NOM});
    key(BU, ST_REF_ADJ4);
    chk(oset, REF4_NOM + 16'h0001);
    ce <= 1'b0;
    op.push(BU);
    ce <= 1'b1;
    chk({st, oset}, {ST_REF_ADJ4, REF4_NOM + 16'h0001});
    key(BE, ST_REF_ZERO);
    chk(nv_seen, NV_REF);
    chk(nvd_seen, 32'h0000_0001);
    key(BU, ST_REF_SPAN);
    key(BP, ST_REF_ADJ20);
    chk({dval, oset}, {REF20_NOM, REF20_NOM});
    key(BE, ST_REF_SPAN);
    key(BE, ST_REF_ITEM);
  endtask : t_ref
  task automatic t_code();
    bsel = 4'h2;
    wb(1'b1, ADR_CODE, 32'h0000_5577, r);
    bsel = 4'hF;
    wb(1'b0, ADR_CODE, 32'h0, r);
    chk(r, 32'h0000_5500);
    wb(1'b1, ADR_CODE, 32'h1209, r);
    wb(1'b0, ADR_CODE, 32'h0, r);
    chk(r, 32'h0000_1209);
    wb(1'b0, 8'hFC, 32'h0, r);
    chk(r, 32'h0);
    key(BP | BD, ST_CODE_P);
    key(BP, ST_CODE_E);
    chk(fdig, 2'h3);
    key(BE, ST_DISP);
    key(BP | BD, ST_CODE_P);
    repeat (260) @(posedge clk_i);
    chk(st, ST_DISP);
    key(BP | BE, ST_CODE_P);
    key(BP, ST_CODE_E);
    digits(16'h1209);
    key(BE, ST_INPUT);
    chk({dp_seen, dpa}, 2'b10);
    key(BP, ST_SENSOR);
    key(BU, ST_SENSOR);
    chk(dval, 16'h0001);
    key(BD, ST_SENSOR);
    key(BP, ST_TC_TYPE);
    key(BP, ST_TC_CH);
    key(BD, ST_TC_CH);
    chk(dval, 16'h0006);
    key(BE, ST_TC_TYPE);
    do_reset();
    wb(1'b1, ADR_CODE, 32'h1209, r);
    key(BP | BD, ST_CODE_P);
    key(BP, ST_CODE_E);
    digits(16'h1209);
    key(BE, ST_ZERO);
  endtask : t_code
  initial begin
    do_reset();
    t_trim_free();
    do_reset();
    t_ref();
    do_reset();
    t_code();
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
endmodule : tmc_trim_menu_bench
